/* File: hdl/dewc_pkg.sv */
// shared constants and carrier types for the data eeprom write controller
package dewc_pkg;

  localparam int          DEWC_ADDR_W      = 16;
  localparam int          DEWC_DATA_W      = 8;
  localparam int          DEWC_LATCHES     = 32;
  localparam int          DEWC_SLOT_W      = 5;

  // register map
  localparam logic [15:0] DEWC_FLASH_CTRL_ADDR  = 16'h002F;
  localparam logic [15:0] DEWC_EEPROM_CTRL_ADDR = 16'h0030;
  localparam logic [7:0]  DEWC_FLASH_CTRL_RST   = 8'h00;
  localparam logic [7:0]  DEWC_EEPROM_CTRL_RST  = 8'h00;

  // eeprom_prog_control fields
  localparam int          DEWC_TRIG_BIT    = 0;
  localparam int          DEWC_WMS_BIT     = 1;
  localparam logic [5:0]  DEWC_EECTRL_PAD  = 6'h00;

  // flash_prog_control fields
  localparam int          DEWC_FPS_BIT     = 0;
  localparam int          DEWC_FHB_BIT     = 1;
  localparam int          DEWC_FCS_BIT     = 2;
  localparam logic [4:0]  DEWC_FCTRL_PAD   = 5'h00;

  // erased cell content and eeprom window
  localparam logic [7:0]  DEWC_ERASED      = 8'hFF;
  localparam logic [15:0] DEWC_EE_BASE     = 16'h1000;
  localparam int          DEWC_EE_BYTES    = 128;
  localparam int          DEWC_PROG_CYCLES = 4000;

  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [DEWC_ADDR_W-1:0] addr;
    logic [DEWC_DATA_W-1:0] wdata;
  } dewc_bus_req_t;

  typedef struct packed {
    logic flash_cfgrow_select;
    logic flash_hold_bit;
    logic flash_prog_start;
  } dewc_flash_ctrl_t;

  typedef enum logic [0:0] {
    DEWC_IDLE,
    DEWC_PROG
  } dewc_state_t;

endpackage

/* File: hdl/dewc_latch_slot.sv */
// one byte of the page latch, and-ing repeated writes
`timescale 1ns/1ps
module dewc_latch_slot #(
  parameter int DATA_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              clear,
  output logic      [DATA_W-1:0] data,
  output logic                   valid
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data  <= '1;
      valid <= 1'b0;
    end else if (clear) begin
      data  <= '1;
      valid <= 1'b0;
    end else if (wr_en) begin
      data  <= data & wdata;
      valid <= 1'b1;
    end
  end

  property p_and_merge;
    @(posedge clock) disable iff (!rst_n)
    (wr_en && !clear) |=> (data == ($past(data) & $past(wdata))) && valid;
  endproperty
  a_and_merge: assert property (p_and_merge)
    else $error("latch slot did not merge by and");

endmodule // dewc_latch_slot

/* File: hdl/dewc_top.sv */
// data eeprom write controller: page latch, programming timer, registers
`timescale 1ns/1ps
module dewc_top
  import dewc_pkg::*;
#(
  parameter logic [15:0] EE_BASE     = DEWC_EE_BASE,
  parameter int          EE_BYTES    = DEWC_EE_BYTES,
  parameter int          PROG_CYCLES = DEWC_PROG_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire dewc_bus_req_t    bus_req,
  input  wire logic             wait_req,
  input  wire logic             halt_req,
  input  wire logic             rop_enable,
  output logic [7:0]            bus_rdata,
  output logic                  bus_rdata_oe,
  output dewc_flash_ctrl_t      flash_ctrl,
  output logic                  eeprom_lowpower,
  output logic                  eeprom_halted,
  output logic                  full_erase_req
);

  localparam int OFF_W = $clog2(EE_BYTES);
  localparam int ROW_W = OFF_W - DEWC_SLOT_W;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [15:0] EE_END = 16'(int'(EE_BASE) + EE_BYTES);

  //////////////////////////////////////////////////////////////////////////
  // state

  dewc_state_t              state;
  logic [CNT_W-1:0]         cnt;
  logic                     trig;
  logic                     wms;
  logic [ROW_W-1:0]         row;
  logic                     rop_q;
  logic [7:0]               mem [EE_BYTES];
  logic [7:0]               slot_data  [DEWC_LATCHES];
  logic [DEWC_LATCHES-1:0]  slot_valid;

  //////////////////////////////////////////////////////////////////////////
  // address decode

  logic             in_ee;
  logic [OFF_W-1:0] ee_off;
  logic             hit_eectl;
  logic             hit_fctl;
  logic             wr_ee;
  logic             rd_ee;
  logic             wr_eectl;
  logic             wr_fctl;

  always_comb begin
    in_ee     = (bus_req.addr >= EE_BASE) && (bus_req.addr < EE_END);
    ee_off    = OFF_W'(bus_req.addr - EE_BASE);
    hit_eectl = 1'b0;
    hit_fctl  = 1'b0;
    if (bus_req.addr == DEWC_EEPROM_CTRL_ADDR) begin
      hit_eectl = 1'b1;
    end else if (bus_req.addr == DEWC_FLASH_CTRL_ADDR) begin
      hit_fctl = 1'b1;
    end
    wr_ee    = bus_req.wr && in_ee;
    rd_ee    = bus_req.rd && in_ee;
    wr_eectl = bus_req.wr && hit_eectl;
    wr_fctl  = bus_req.wr && hit_fctl;
  end

  //////////////////////////////////////////////////////////////////////////
  // control events

  logic rop_fall;
  logic sw_start;
  logic sw_abort;
  logic hw_abort;
  logic prog_done;
  logic latch_wr;
  logic latch_clear;
  logic wms_sw_clear;

  always_comb begin
    // protection removal is seen only once the strap has been sampled
    rop_fall  = rop_q && !rop_enable;
    sw_start  = wr_eectl && bus_req.wdata[DEWC_TRIG_BIT] && !trig
                && (wms || bus_req.wdata[DEWC_WMS_BIT])
                && (state == DEWC_IDLE) && !halt_req && !rop_enable
                && !rop_fall && !eeprom_lowpower;
    sw_abort  = wr_eectl && !bus_req.wdata[DEWC_TRIG_BIT] && trig;
    hw_abort  = halt_req || rop_fall;
    prog_done = (state == DEWC_PROG) && (cnt == CNT_LAST)
                && !sw_abort && !hw_abort;
    // write mode only, no programming running, not protected
    latch_wr  = wr_ee && wms && !trig && (state == DEWC_IDLE)
                && !rop_enable;
    wms_sw_clear = wr_eectl && !bus_req.wdata[DEWC_WMS_BIT] && !trig
                   && wms;
    latch_clear  = prog_done || wms_sw_clear;
  end

  //////////////////////////////////////////////////////////////////////////
  // page latch: 32 slots, no read path back to the bus

  for (genvar i = 0; i < DEWC_LATCHES; i++) begin : g_slot
    dewc_latch_slot #(
      .DATA_W (DEWC_DATA_W)
    ) u_slot (
      .clock (clock),
      .rst_n (rst_n),
      .wr_en (latch_wr && (ee_off[DEWC_SLOT_W-1:0] == DEWC_SLOT_W'(i))),
      .wdata (bus_req.wdata),
      .clear (latch_clear),
      .data  (slot_data[i]),
      .valid (slot_valid[i])
    );
  end

  // row follows the last latch write; software keeps it constant
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row <= '0;
    end else if (latch_wr) begin
      row <= ee_off[OFF_W-1:DEWC_SLOT_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // eeprom_prog_control bits

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig <= DEWC_EEPROM_CTRL_RST[DEWC_TRIG_BIT];
      wms  <= DEWC_EEPROM_CTRL_RST[DEWC_WMS_BIT];
    end else if (prog_done) begin
      trig <= 1'b0;
      wms  <= 1'b0;
    end else if (hw_abort) begin
      trig <= 1'b0;
    end else if (wr_eectl) begin
      if (sw_start) begin
        trig <= 1'b1;
      end else if (sw_abort) begin
        trig <= 1'b0;
      end
      if (bus_req.wdata[DEWC_WMS_BIT]) begin
        wms <= 1'b1;
      end else if (!trig) begin
        wms <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // programming sequencer

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= DEWC_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        DEWC_IDLE: begin
          cnt <= '0;
          if (sw_start) begin
            state <= DEWC_PROG;
          end
        end
        DEWC_PROG: begin
          if (sw_abort || hw_abort) begin
            state <= DEWC_IDLE;
          end else if (cnt == CNT_LAST) begin
            state <= DEWC_IDLE;
          end else begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        default: state <= DEWC_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // array: commits at the end of a cycle; a halt or software abort leaves it untouched here (protection removal erases it),
  // real cells may be left half programmed

  always_ff @(posedge clock) begin
    if (rop_fall) begin
      for (int a = 0; a < EE_BYTES; a++) begin
        mem[a] <= DEWC_ERASED;
      end
    end else if (prog_done) begin
      for (int b = 0; b < DEWC_LATCHES; b++) begin
        if (slot_valid[b]) begin
          mem[{row, DEWC_SLOT_W'(b)}] <= slot_data[b];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // protection strap, erase request, power modes

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rop_q          <= 1'b0;
      full_erase_req <= 1'b0;
    end else begin
      rop_q          <= rop_enable;
      full_erase_req <= rop_fall;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_lowpower <= 1'b0;
      eeprom_halted   <= 1'b0;
    end else begin
      // a running cycle is finished before low power is entered
      eeprom_lowpower <= wait_req && (state == DEWC_IDLE)
                         && !sw_start;
      eeprom_halted   <= halt_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flash_prog_control

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_ctrl.flash_cfgrow_select <= DEWC_FLASH_CTRL_RST[DEWC_FCS_BIT];
      flash_ctrl.flash_hold_bit      <= DEWC_FLASH_CTRL_RST[DEWC_FHB_BIT];
      flash_ctrl.flash_prog_start    <= DEWC_FLASH_CTRL_RST[DEWC_FPS_BIT];
    end else if (wr_fctl) begin
      flash_ctrl.flash_cfgrow_select <= bus_req.wdata[DEWC_FCS_BIT];
      flash_ctrl.flash_hold_bit      <= bus_req.wdata[DEWC_FHB_BIT];
      flash_ctrl.flash_prog_start    <= bus_req.wdata[DEWC_FPS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the request

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata    <= 8'h00;
      bus_rdata_oe <= 1'b0;
    end else begin
      bus_rdata_oe <= 1'b0;
      if (bus_req.rd && hit_eectl) begin
        bus_rdata    <= {DEWC_EECTRL_PAD, wms, trig};
        bus_rdata_oe <= 1'b1;
      end else if (bus_req.rd && hit_fctl) begin
        bus_rdata    <= {DEWC_FCTRL_PAD, flash_ctrl.flash_cfgrow_select,
                         flash_ctrl.flash_hold_bit,
                         flash_ctrl.flash_prog_start};
        bus_rdata_oe <= 1'b1;
      end else if (rd_ee && !wms && !rop_enable) begin
        bus_rdata    <= mem[ee_off];
        bus_rdata_oe <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_start;
    sw_start;
  endsequence

  sequence s_done;
    prog_done;
  endsequence

  property p_start_runs;
    @(posedge clock) disable iff (!rst_n)
    s_start |=> trig && (state == DEWC_PROG) && (cnt == '0);
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("programming did not start with trigger set");

  property p_done_clears;
    @(posedge clock) disable iff (!rst_n)
    s_done |=> !trig && !wms && (slot_valid == '0);
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("completion did not clear trigger and write mode");

  property p_rom_read;
    @(posedge clock) disable iff (!rst_n)
    (rd_ee && !wms && !rop_enable) |=> bus_rdata_oe;
  endproperty
  a_rom_read: assert property (p_rom_read)
    else $error("read mode access returned no data");

  property p_wm_undriven;
    @(posedge clock) disable iff (!rst_n)
    (rd_ee && wms) |=> !bus_rdata_oe;
  endproperty
  a_wm_undriven: assert property (p_wm_undriven)
    else $error("write mode read drove the bus");

  property p_rm_ignored;
    @(posedge clock) disable iff (!rst_n)
    (wr_ee && !wms) |=> $stable(slot_valid);
  endproperty
  a_rm_ignored: assert property (p_rm_ignored)
    else $error("read mode write reached the latches");

  property p_wms_held;
    @(posedge clock) disable iff (!rst_n)
    (wr_eectl && trig && wms && !bus_req.wdata[DEWC_WMS_BIT] && !prog_done)
      |=> wms;
  endproperty
  a_wms_held: assert property (p_wms_held)
    else $error("write mode cleared while programming");

  property p_halt_abort;
    @(posedge clock) disable iff (!rst_n)
    halt_req |=> !trig && (state == DEWC_IDLE) && eeprom_halted;
  endproperty
  a_halt_abort: assert property (p_halt_abort)
    else $error("halt did not stop programming");

  property p_wait_idle;
    @(posedge clock) disable iff (!rst_n)
    (wait_req && (state == DEWC_PROG)) |=> !eeprom_lowpower;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("low power entered during programming");

  property p_ctrl_pad;
    @(posedge clock) disable iff (!rst_n)
    (bus_req.rd && hit_eectl) |=> bus_rdata_oe
      && (bus_rdata[7:2] == DEWC_EECTRL_PAD);
  endproperty
  a_ctrl_pad: assert property (p_ctrl_pad)
    else $error("reserved control bits read nonzero");

  property p_cnt_bound;
    @(posedge clock) disable iff (!rst_n)
    (state == DEWC_PROG) |-> (cnt <= CNT_LAST) && trig;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("programming counter overran its length");

endmodule // dewc_top

/* File: dv/dewc_cpu_model.sv */
// cpu side bus master model issuing eeprom and register accesses
`timescale 1ns/1ps
module dewc_cpu_model
  import dewc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_rdata_oe,
  output dewc_bus_req_t   bus_req
);
  initial bus_req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // no instruction fetch from the eeprom window ever overlaps a write
  // released fields show inverted values so stale data cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    bus_req.wr    <= 1'b0;
    bus_req.wdata <= ~d;
    bus_req.addr  <= ~a;
  endtask
  task automatic rd(input logic [15:0] a, output logic oe,
                    output logic [7:0] d);
    @(negedge clock);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    oe = bus_rdata_oe;
    d  = bus_rdata;
    bus_req.rd   <= 1'b0;
    bus_req.addr <= ~a;
  endtask
endmodule // dewc_cpu_model

/* File: dv/data_eeprom_write_controller_test.sv */
// self-checking bench for the data eeprom write controller
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module data_eeprom_write_controller_test;
  import dewc_pkg::*;
  localparam int    PC   = 16;
  localparam [15:0] CTRL = DEWC_EEPROM_CTRL_ADDR;
  localparam [15:0] FCTL = DEWC_FLASH_CTRL_ADDR;
  logic             clock      = 1'b0;
  logic             rst_n      = 1'b0;
  logic             wait_req   = 1'b0;
  logic             halt_req   = 1'b0;
  logic             rop_enable = 1'b1;
  dewc_bus_req_t    bus_req;
  logic [7:0]       bus_rdata;
  logic             bus_rdata_oe;
  dewc_flash_ctrl_t flash_ctrl;
  logic             eeprom_lowpower;
  logic             eeprom_halted;
  logic             full_erase_req;
  logic             oe;
  logic [7:0]       rd_data;
  int               errors    = 0;
  int               tests_run = 0;
  int               seed      = 32'h9dcc;
  int               n;
  int               mem [DEWC_EE_BYTES];
  int               pend [DEWC_LATCHES];

  always #2 clock = ~clock;

  dewc_top #(.PROG_CYCLES(PC)) dewc_top_inst (
    .clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .wait_req(wait_req), .halt_req(halt_req), .rop_enable(rop_enable),
    .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
    .flash_ctrl(flash_ctrl), .eeprom_lowpower(eeprom_lowpower),
    .eeprom_halted(eeprom_halted), .full_erase_req(full_erase_req));

  dewc_cpu_model dewc_cpu_model_inst (
    .clock(clock), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .bus_req(bus_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    dewc_cpu_model_inst.wr(a, d);
  endtask
  // negative expected data means the byte is not guaranteed
  task automatic rchk(input logic [15:0] a, input logic eo, input int ed);
    dewc_cpu_model_inst.rd(a, oe, rd_data);
    `CHK("read_answer", eo, oe)
    if (eo && ed >= 0) `CHK("read_data", ed[7:0], rd_data)
  endtask
  task automatic lwr(input int row, input int slot, input logic [7:0] d);
    wr(DEWC_EE_BASE + 16'(row * 32 + slot), d);
    pend[slot] = (pend[slot] < 0) ? int'(d) : (pend[slot] & int'(d));
  endtask
  task automatic commit(input int row);
    foreach (pend[i]) if (pend[i] >= 0) mem[row * 32 + i] = pend[i];
    foreach (pend[i]) pend[i] = -1;
  endtask
  task automatic row_chk(input int row);
    for (int i = 0; i < 32; i++)
      rchk(DEWC_EE_BASE + 16'(row * 32 + i), 1'b1, mem[row * 32 + i]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    final_report();
  end
  initial begin
    foreach (pend[i]) pend[i] = -1;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    rchk(FCTL, 1'b1, 0);
    rchk(CTRL, 1'b1, 0);
    rchk(DEWC_EE_BASE, 1'b0, -1);
    @(negedge clock);
    rop_enable = 1'b0;
    n = 0;
    repeat (4) begin
      @(negedge clock);
      n += int'(full_erase_req === 1'b1);
    end
    `CHK("erase_pulses", 1, n)
    foreach (mem[i]) mem[i] = 8'hFF;
    row_chk(3);
    $display("test protect_removal done");
    for (int k = 0; k < 4; k++) begin
      n = ($random(seed) & 248) | (k + 3);
      wr(FCTL, 8'(n));
      rchk(FCTL, 1'b1, n & 7);
      `CHK("flash_ctrl_rand", n[2:0], flash_ctrl)
    end
    wr(FCTL, 8'h56);
    wr(FCTL, 8'hAE);
    rchk(FCTL, 1'b1, 8'h06);
    `CHK("flash_ctrl", 3'h6, flash_ctrl)
    wr(CTRL, 8'hFC);
    rchk(CTRL, 1'b1, 0);
    wr(DEWC_EE_BASE + 16'h0040, 8'h00);
    $display("test registers done");
    // page program with random slots, an and-merge and the last slot
    wr(CTRL, 8'h02);
    rchk(CTRL, 1'b1, 2);
    rchk(DEWC_EE_BASE + 16'h0020, 1'b0, -1);
    for (int k = 0; k < 12; k++)
      lwr(1, $random(seed) & 31, 8'($random(seed)));
    lwr(1, 0, 8'hF0);
    lwr(1, 0, 8'h3C);
    lwr(1, 31, 8'hA5);
    wr(CTRL, 8'h03);
    rchk(CTRL, 1'b1, 3);
    wr(CTRL, 8'h01);
    rchk(CTRL, 1'b1, 3);
    repeat (PC) @(negedge clock);
    rchk(CTRL, 1'b1, 0);
    commit(1);
    row_chk(1);
    row_chk(2);
    $display("test page_program done");
    // a falling write-mode bit must drop what was latched
    wr(CTRL, 8'h02);
    lwr(2, 5, 8'h00);
    wr(CTRL, 8'h00);
    foreach (pend[i]) pend[i] = -1;
    wr(CTRL, 8'h02);
    wr(CTRL, 8'h03);
    repeat (PC + 4) @(negedge clock);
    rchk(DEWC_EE_BASE + 16'h0045, 1'b1, mem[69]);
    $display("test latch_clear done");
    wr(CTRL, 8'h02);
    lwr(0, 1, 8'h11);
    wr(CTRL, 8'h03);
    wr(CTRL, 8'h02);
    rchk(CTRL, 1'b1, 2);
    wr(CTRL, 8'h00);
    foreach (pend[i]) pend[i] = -1;
    $display("test trigger_abort done");
    wr(CTRL, 8'h02);
    lwr(0, 2, 8'h22);
    wr(CTRL, 8'h03);
    halt_req = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("halted", 1'b1, eeprom_halted)
    halt_req = 1'b0;
    repeat (2) @(negedge clock);
    dewc_cpu_model_inst.rd(CTRL, oe, rd_data);
    `CHK("trigger_after_halt", 1'b0, rd_data[0])
    wr(CTRL, 8'h00);
    foreach (pend[i]) pend[i] = -1;
    $display("test halt done");
    wait_req = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("lowpower_idle", 1'b1, eeprom_lowpower)
    wait_req = 1'b0;
    repeat (2) @(negedge clock);
    wr(CTRL, 8'h02);
    lwr(3, 4, 8'h44);
    wr(CTRL, 8'h03);
    wait_req = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("lowpower_busy", 1'b0, eeprom_lowpower)
    repeat (PC + 2) @(negedge clock);
    `CHK("lowpower_after", 1'b1, eeprom_lowpower)
    wait_req = 1'b0;
    repeat (2) @(negedge clock);
    commit(3);
    rchk(DEWC_EE_BASE + 16'h0064, 1'b1, mem[100]);
    $display("test wait done");
    wr(CTRL, 8'h02);
    lwr(3, 6, 8'h66);
    wr(CTRL, 8'h03);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rchk(CTRL, 1'b1, 0);
    rchk(FCTL, 1'b1, 0);
    $display("test reset_abort done");
    final_report();
  end
endmodule // data_eeprom_write_controller_test
